// File: core/tmc_timer16.v
// Sixteen-bit timer/counter with mode decoding, capture, prescaler, forced compare and byte access.
`timescale 1ns/1ns
`include "tmc_defines.vh"
module tmc_timer16 #(
  parameter FILTER_SAMPLES = `TMC_FILTER_SAMPLES
) (
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  input  wire       regRdEn,
  input  wire [1:0] waveformModeLow,
  input  wire [1:0] compareOutputModeA,
  input  wire [1:0] compareOutputModeB,
  input  wire       capturePin,
  input  wire       externalClockPin,
  output reg  [7:0] regRdData,
  output reg        waveformOutputA,
  output reg        waveformOutputB,
  output reg        overflowFlagSet,
  output reg        captureFlagSet,
  output reg        compareMatchASet,
  output reg        compareMatchBSet
);

  localparam KIND_NORMAL = 2'h0;
  localparam KIND_FAST   = 2'h1;
  localparam KIND_PHASE  = 2'h2;
  localparam KIND_PFC    = 2'h3;

  reg  [7:0]                  ctrlB_reg;
  reg  [15:0]                 count_reg;
  reg                         countUp_reg;
  reg  [7:0]                  temp_reg;
  reg  [15:0]                 capture_reg;
  reg  [15:0]                 cmpA_reg;
  reg  [15:0]                 cmpB_reg;
  reg  [15:0]                 cmpABuf_reg;
  reg  [15:0]                 cmpBBuf_reg;
  reg                         block_reg;
  reg  [`TMC_PRESC_WIDTH-1:0] presc_reg;
  reg                         extPrev_reg;
  reg  [FILTER_SAMPLES-1:0]   capShift_reg;
  reg                         capFilt_reg;
  reg                         capPrev_reg;

  wire [3:0] mode = {ctrlB_reg[`TMC_BIT_WGM3], ctrlB_reg[`TMC_BIT_WGM2], waveformModeLow};
  wire [2:0] clkSel = ctrlB_reg[2:0];

  function [1:0] mode_kind;
    input [3:0] m;
    begin
      case (m)
        4'd1, 4'd2, 4'd3, 4'd10, 4'd11: mode_kind = KIND_PHASE;
        4'd5, 4'd6, 4'd7, 4'd14, 4'd15: mode_kind = KIND_FAST;
        4'd8, 4'd9:                     mode_kind = KIND_PFC;
        default:                        mode_kind = KIND_NORMAL;
      endcase
    end
  endfunction

  // Next level of one waveform output given its hit, the wrap to bottom and the count direction.
  function wave_next;
    input [1:0] kind;
    input [3:0] m;
    input [1:0] com;
    input       cur;
    input       hit;
    input       wrap;
    input       up;
    input       chanA;
    begin
      wave_next = cur;
      case (kind)
        KIND_NORMAL: begin
          if (hit) begin
            case (com)
              2'b01:   wave_next = ~cur;
              2'b10:   wave_next = 1'b0;
              2'b11:   wave_next = 1'b1;
              default: wave_next = cur;
            endcase
          end
        end
        KIND_FAST: begin
          case (com)
            2'b01:   wave_next = (hit && chanA && (m == 4'd14 || m == 4'd15)) ? ~cur : cur;
            2'b10:   wave_next = wrap ? 1'b1 : (hit ? 1'b0 : cur);
            2'b11:   wave_next = wrap ? 1'b0 : (hit ? 1'b1 : cur);
            default: wave_next = cur;
          endcase
        end
        default: begin
          case (com)
            2'b01:   wave_next = (hit && chanA && (m == 4'd9 || m == 4'd11)) ? ~cur : cur;
            2'b10:   wave_next = hit ? ~up : cur;
            2'b11:   wave_next = hit ? up : cur;
            default: wave_next = cur;
          endcase
        end
      endcase
    end
  endfunction

  wire [1:0] kind = mode_kind(mode);
  reg  [15:0] top;

  always @* begin
    case (mode)
      4'd1, 4'd5:                  top = `TMC_TOP_8BIT;
      4'd2, 4'd6:                  top = `TMC_TOP_9BIT;
      4'd3, 4'd7:                  top = `TMC_TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15:    top = cmpA_reg;
      4'd8, 4'd10, 4'd12, 4'd14:   top = capture_reg;
      default:                     top = `TMC_TOP_MAX;
    endcase
  end

  // Capture-as-top modes free the capture register for use as a limit.
  wire captureIsTop = (mode == 4'd8) || (mode == 4'd10) || (mode == 4'd12) || (mode == 4'd14);

  wire extNow = externalClockPin;
  reg  tick;
  always @* begin
    case (clkSel)
      3'b001:  tick = 1'b1;
      3'b010:  tick = (presc_reg & `TMC_DIV8_MASK) == `TMC_DIV8_MASK;
      3'b011:  tick = (presc_reg & `TMC_DIV64_MASK) == `TMC_DIV64_MASK;
      3'b100:  tick = (presc_reg & `TMC_DIV256_MASK) == `TMC_DIV256_MASK;
      3'b101:  tick = (presc_reg & `TMC_DIV1024_MASK) == `TMC_DIV1024_MASK;
      3'b110:  tick = extPrev_reg & ~extNow;
      3'b111:  tick = ~extPrev_reg & extNow;
      default: tick = 1'b0;
    endcase
  end

  // Counting sequence for the selected kind; events flag top and bottom.
  reg [15:0] countNext;
  reg        upNext;
  reg        topEvt;
  reg        botEvt;
  always @* begin
    countNext = count_reg;
    upNext    = countUp_reg;
    topEvt    = 1'b0;
    botEvt    = 1'b0;
    if (tick) begin
      case (kind)
        KIND_FAST: begin
          if (count_reg >= top) begin
            countNext = 16'h0000;
            topEvt    = 1'b1;
          end else begin
            countNext = count_reg + 16'h0001;
          end
        end
        KIND_PHASE, KIND_PFC: begin
          if (countUp_reg) begin
            if (count_reg >= top) begin
              countNext = count_reg - 16'h0001;
              upNext    = 1'b0;
              topEvt    = 1'b1;
            end else begin
              countNext = count_reg + 16'h0001;
            end
          end else if (count_reg == 16'h0000) begin
            countNext = 16'h0001;
            upNext    = 1'b1;
            botEvt    = 1'b1;
          end else begin
            countNext = count_reg - 16'h0001;
          end
        end
        default: begin
          topEvt    = count_reg == top;
          countNext = (count_reg == top) ? 16'h0000 : count_reg + 16'h0001;
        end
      endcase
    end
  end

  wire overflowEvt = (kind == KIND_NORMAL) ? (tick && count_reg == `TMC_TOP_MAX) :
                     (kind == KIND_FAST)   ? topEvt :
                     botEvt;
  wire updateEvt   = (kind == KIND_PHASE) ? topEvt :
                     botEvt | (kind == KIND_FAST && topEvt);
  wire matchA = tick && !block_reg && count_reg == cmpA_reg;
  wire matchB = tick && !block_reg && count_reg == cmpB_reg;

  wire isWrite = regWrEn;
  wire wrCtrlC = isWrite && regAddr == `TMC_ADDR_CTRL_C;
  wire forceA  = wrCtrlC && regWrData[`TMC_BIT_FORCE_A] && kind == KIND_NORMAL;
  wire forceB  = wrCtrlC && regWrData[`TMC_BIT_FORCE_B] && kind == KIND_NORMAL;
  wire wrCountL = isWrite && regAddr == `TMC_ADDR_COUNT_L;

  // The filter needs its whole window equal before the filtered level may move.
  wire filterAll1 = &capShift_reg;
  wire filterAll0 = ~|capShift_reg;
  wire capNext = ctrlB_reg[`TMC_BIT_FILTER] ?
                 (filterAll1 ? 1'b1 : (filterAll0 ? 1'b0 : capFilt_reg)) : capturePin;
  wire capEdge = ctrlB_reg[`TMC_BIT_EDGE] ? (capFilt_reg & ~capPrev_reg) :
                 (~capFilt_reg & capPrev_reg);
  wire captureEvt = capEdge && !captureIsTop;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlB_reg        <= `TMC_CTRL_B_RESET;
      count_reg        <= 16'h0000;
      countUp_reg      <= 1'b1;
      temp_reg         <= 8'h00;
      capture_reg      <= 16'h0000;
      cmpA_reg         <= 16'h0000;
      cmpB_reg         <= 16'h0000;
      cmpABuf_reg      <= 16'h0000;
      cmpBBuf_reg      <= 16'h0000;
      block_reg        <= 1'b0;
      presc_reg        <= {`TMC_PRESC_WIDTH{1'b0}};
      extPrev_reg      <= 1'b0;
      capShift_reg     <= {FILTER_SAMPLES{1'b0}};
      capFilt_reg      <= 1'b0;
      capPrev_reg      <= 1'b0;
      regRdData        <= 8'h00;
      waveformOutputA  <= 1'b0;
      waveformOutputB  <= 1'b0;
      overflowFlagSet  <= 1'b0;
      captureFlagSet   <= 1'b0;
      compareMatchASet <= 1'b0;
      compareMatchBSet <= 1'b0;
    end else begin
      presc_reg    <= presc_reg + {{(`TMC_PRESC_WIDTH-1){1'b0}}, 1'b1};
      extPrev_reg  <= extNow;
      capShift_reg <= {capShift_reg[FILTER_SAMPLES-2:0], capturePin};
      capFilt_reg  <= capNext;
      capPrev_reg  <= capFilt_reg;

      // A software counter write takes precedence over the tick in the same cycle.
      if (wrCountL) begin
        count_reg <= {temp_reg, regWrData};
        block_reg <= 1'b1;
      end else begin
        count_reg   <= countNext;
        countUp_reg <= upNext;
        if (tick) begin
          block_reg <= 1'b0;
        end
      end

      if (updateEvt && kind != KIND_NORMAL) begin
        cmpA_reg <= cmpABuf_reg;
        cmpB_reg <= cmpBBuf_reg;
      end else if (kind == KIND_NORMAL) begin
        cmpA_reg <= cmpABuf_reg;
        cmpB_reg <= cmpBBuf_reg;
      end

      if (captureEvt) begin
        capture_reg <= count_reg;
      end else if (isWrite && regAddr == `TMC_ADDR_CAPT_L) begin
        capture_reg <= {temp_reg, regWrData};
      end

      overflowFlagSet  <= overflowEvt;
      captureFlagSet   <= captureEvt;
      compareMatchASet <= matchA;
      compareMatchBSet <= matchB;

      waveformOutputA <= wave_next(kind, mode, compareOutputModeA, waveformOutputA,
                                   matchA | forceA, updateEvt & (kind == KIND_FAST), countUp_reg, 1'b1);
      waveformOutputB <= wave_next(kind, mode, compareOutputModeB, waveformOutputB,
                                   matchB | forceB, updateEvt & (kind == KIND_FAST), countUp_reg, 1'b0);

      if (isWrite) begin
        case (regAddr)
          `TMC_ADDR_CTRL_B: ctrlB_reg   <= regWrData & `TMC_CTRL_B_MASK;
          `TMC_ADDR_COUNT_H,
          `TMC_ADDR_CAPT_H,
          `TMC_ADDR_CMPA_H,
          `TMC_ADDR_CMPB_H: temp_reg    <= regWrData;
          `TMC_ADDR_CMPA_L: cmpABuf_reg <= {temp_reg, regWrData};
          `TMC_ADDR_CMPB_L: cmpBBuf_reg <= {temp_reg, regWrData};
          default:          temp_reg    <= temp_reg;
        endcase
      end

      if (regRdEn) begin
        case (regAddr)
          `TMC_ADDR_CTRL_B: regRdData <= ctrlB_reg & `TMC_CTRL_B_MASK;
          `TMC_ADDR_CTRL_C: regRdData <= 8'h00;
          `TMC_ADDR_COUNT_L: begin
            regRdData <= count_reg[7:0];
            temp_reg  <= count_reg[15:8];
          end
          `TMC_ADDR_CAPT_L: begin
            regRdData <= capture_reg[7:0];
            temp_reg  <= capture_reg[15:8];
          end
          `TMC_ADDR_COUNT_H,
          `TMC_ADDR_CAPT_H: regRdData <= temp_reg;
          `TMC_ADDR_CMPA_L: regRdData <= cmpABuf_reg[7:0];
          `TMC_ADDR_CMPA_H: regRdData <= cmpABuf_reg[15:8];
          `TMC_ADDR_CMPB_L: regRdData <= cmpBBuf_reg[7:0];
          `TMC_ADDR_CMPB_H: regRdData <= cmpBBuf_reg[15:8];
          default:          regRdData <= 8'h00;
        endcase
      end
    end
  end

endmodule // tmc_timer16

// File: core/tmc_defines.vh
// Offsets, field positions, reset values and timing counts of the 16-bit timer.
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH
`define TMC_ADDR_CTRL_B     8'h81
`define TMC_ADDR_CTRL_C     8'h82
`define TMC_ADDR_COUNT_L    8'h84
`define TMC_ADDR_COUNT_H    8'h85
`define TMC_ADDR_CAPT_L     8'h86
`define TMC_ADDR_CAPT_H     8'h87
`define TMC_ADDR_CMPA_L     8'h88
`define TMC_ADDR_CMPA_H     8'h89
`define TMC_ADDR_CMPB_L     8'h8A
`define TMC_ADDR_CMPB_H     8'h8B
`define TMC_CTRL_B_RESET    8'h00
`define TMC_CTRL_B_MASK     8'hDF
`define TMC_BIT_FILTER      7
`define TMC_BIT_EDGE        6
`define TMC_BIT_WGM3        4
`define TMC_BIT_WGM2        3
`define TMC_BIT_FORCE_A     7
`define TMC_BIT_FORCE_B     6
`define TMC_TOP_MAX         16'hFFFF
`define TMC_TOP_8BIT        16'h00FF
`define TMC_TOP_9BIT        16'h01FF
`define TMC_TOP_10BIT       16'h03FF
`define TMC_FILTER_SAMPLES  4
`define TMC_PRESC_WIDTH     10
`define TMC_DIV8_MASK       10'h0007
`define TMC_DIV64_MASK      10'h003F
`define TMC_DIV256_MASK     10'h00FF
`define TMC_DIV1024_MASK    10'h03FF
`endif

// File: core/tmc_empty_placeholder_none.v
// Intentionally holds no module; keeps the design to its single logic file.
`timescale 1ns/1ns

// File: testbench/tmc_timer16_assertions.sv
// Port-level concurrent checks for the 16-bit timer.
`timescale 1ns/1ns
module tmc_timer16_assertions #(
  parameter FILTER_SAMPLES = 4
) (
  input wire       ref_clk,
  input wire       rst_b,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrEn,
  input wire       regRdEn,
  input wire [1:0] waveformModeLow,
  input wire [1:0] compareOutputModeA,
  input wire [1:0] compareOutputModeB,
  input wire       capturePin,
  input wire       externalClockPin,
  input wire [7:0] regRdData,
  input wire       waveformOutputA,
  input wire       waveformOutputB,
  input wire       overflowFlagSet,
  input wire       captureFlagSet,
  input wire       compareMatchASet,
  input wire       compareMatchBSet
);
  reg  [7:0] ctrlB_reg;
  reg        expA_reg;
  wire [3:0] mode    = {ctrlB_reg[4:3], waveformModeLow};
  wire       pwmMode = (mode != 4'h0) && (mode != 4'h4) && (mode != 4'hC);
  wire       icrTop  = mode[3] && !mode[0];
  wire       stopped = (ctrlB_reg[2:0] == 3'h0);
  wire       forceA  = regWrEn && (regAddr == 8'h82) && regWrData[7];
  // The checker sees only ports, so it keeps its own copy of the control bits.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlB_reg <= 8'h00;
      expA_reg  <= 1'b0;
    end else begin
      if (regWrEn && (regAddr == 8'h81)) ctrlB_reg <= regWrData & 8'hDF;
      if (forceA) expA_reg <= (compareOutputModeA == 2'h1) ? !waveformOutputA : compareOutputModeA[0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence capEdge_s;
    !ctrlB_reg[7] && !icrTop && (ctrlB_reg[6] ? $rose(capturePin) : $fell(capturePin));
  endsequence
  sequence filtRise_s;
    ctrlB_reg[7] && ctrlB_reg[6] && !icrTop && $rose(capturePin) ##1 capturePin [*3];
  endsequence
  unmapped_read_a: assert property (
    regRdEn && !(regAddr inside {8'h81, 8'h82, [8'h84:8'h8B]}) |=> regRdData == 8'h00)
    else $error("Unmapped read gave nonzero data.");
  force_read_a: assert property (regRdEn && regAddr == 8'h82 |=> regRdData[7:6] == 2'h0)
    else $error("Force bits read back as one.");
  ctrlb_readback_a: assert property (regRdEn && regAddr == 8'h81 && !regWrEn |=> regRdData == $past(ctrlB_reg))
    else $error("Control B read back differs from last write.");
  read_hold_a: assert property (!regRdEn |=> $stable(regRdData))
    else $error("Read data changed without a read.");
  stop_no_tick_a: assert property (stopped && $past(stopped) && $past(stopped, 2) |->
    !overflowFlagSet && !compareMatchASet && !compareMatchBSet)
    else $error("Timer event while the clock is stopped.");
  force_apply_a: assert property (stopped && !pwmMode && forceA && compareOutputModeA != 2'h0 |=>
    ##[0:1] waveformOutputA == expA_reg)
    else $error("Forced compare did not act on output A.");
  pwm_force_a: assert property (stopped && pwmMode && forceA |=> $stable(waveformOutputA) [*2])
    else $error("Forced compare acted in a PWM mode.");
  capture_off_a: assert property (captureFlagSet |-> !icrTop && !$past(icrTop))
    else $error("Capture while the capture register is top.");
  edge_capture_a: assert property (capEdge_s |-> ##[1:4] captureFlagSet)
    else $error("Selected capture edge gave no capture.");
  filter_hold_a: assert property (ctrlB_reg[7] && $rose(capturePin) |-> !captureFlagSet [*4])
    else $error("Filtered capture came too early.");
  filter_delay_a: assert property (filtRise_s |-> ##[1:6] captureFlagSet)
    else $error("Filtered capture never came.");
endmodule // tmc_timer16_assertions
bind tmc_timer16 tmc_timer16_assertions #(.FILTER_SAMPLES(FILTER_SAMPLES)) i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .waveformModeLow(waveformModeLow), .compareOutputModeA(compareOutputModeA),
  .compareOutputModeB(compareOutputModeB), .capturePin(capturePin), .externalClockPin(externalClockPin),
  .regRdData(regRdData), .waveformOutputA(waveformOutputA), .waveformOutputB(waveformOutputB),
  .overflowFlagSet(overflowFlagSet), .captureFlagSet(captureFlagSet),
  .compareMatchASet(compareMatchASet), .compareMatchBSet(compareMatchBSet));

// File: testbench/tmc_timer16_bench.sv
// Self-checking bench for the 16-bit timer.
`timescale 1ns/1ns
module tmc_timer16_bench;
  reg         ref_clk, rst_b, regWrEn, regRdEn, capturePin, externalClockPin, pa, pb, hit;
  reg  [7:0]  regAddr, regWrData, d;
  reg  [1:0]  waveformModeLow, compareOutputModeA, compareOutputModeB;
  reg  [3:0]  m;
  reg  [15:0] v, t, s;
  reg  [31:0] seed;
  wire [7:0]  regRdData;
  wire        waveformOutputA, waveformOutputB, overflowFlagSet, captureFlagSet, compareMatchASet, compareMatchBSet;
  integer     bad_count, tests_run, cycles, i, n, e;
  tmc_timer16 i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .waveformModeLow(waveformModeLow),
    .compareOutputModeA(compareOutputModeA), .compareOutputModeB(compareOutputModeB),
    .capturePin(capturePin), .externalClockPin(externalClockPin), .regRdData(regRdData),
    .waveformOutputA(waveformOutputA), .waveformOutputB(waveformOutputB), .overflowFlagSet(overflowFlagSet),
    .captureFlagSet(captureFlagSet), .compareMatchASet(compareMatchASet), .compareMatchBSet(compareMatchBSet));
  always #5 ref_clk = ~ref_clk;
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [15:0] topOf(input [3:0] k);
    topOf = (k[1:0] == 2'h1) ? 16'h00FF : (k[1:0] == 2'h2) ? 16'h01FF : (k[1:0] == 2'h3) ? 16'h03FF : 16'hFFFF;
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Strobes rise on a falling edge and fall on the next, so each is seen by exactly one rising edge.
  task wr(input [7:0] a, input [7:0] x);
    begin
      @(negedge ref_clk);
      regAddr = a;
      regWrData = x;
      regWrEn = 1'b1;
      @(negedge ref_clk);
      regWrEn = 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] x);
    begin
      @(negedge ref_clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge ref_clk);
      regRdEn = 1'b0;
      @(negedge ref_clk);
      x = regRdData;
    end
  endtask
  task wr16(input [7:0] a, input [15:0] x);
    begin
      wr(a + 8'h01, x[15:8]);
      wr(a, x[7:0]);
    end
  endtask
  task rd16(input [7:0] a, output [15:0] x);
    begin
      rd(a, x[7:0]);
      rd(a + 8'h01, x[15:8]);
    end
  endtask
  task ctrl(input [3:0] k, input [2:0] c, input [1:0] fe);
    begin
      waveformModeLow = k[1:0];
      wr(8'h81, {fe, 1'b0, k[3:2], c});
    end
  endtask
  task pin(input x, input integer w);
    begin
      capturePin = x;
      repeat (w) begin
        @(negedge ref_clk);
        hit = hit | captureFlagSet;
      end
    end
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  initial begin
    {ref_clk, rst_b, regWrEn, regRdEn, capturePin, externalClockPin, hit} = 7'h00;
    {regAddr, regWrData, waveformModeLow, compareOutputModeA, compareOutputModeB} = 22'h00_0000;
    {bad_count, tests_run, cycles} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    seed = 32'h0000_DA36;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      rd(8'h81 + i[7:0], d);
      chk({8'h00, d}, 16'h0000);
    end
    seed = xs(seed);
    wr(8'h81, seed[7:0] & 8'hD8);
    rd(8'h81, d);
    chk({8'h00, d}, {8'h00, seed[7:0] & 8'hD8});
    wr(8'h82, 8'hC0);
    rd(8'h82, d);
    chk({8'h00, d}, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      wr16(8'h84, seed[15:0]);
      rd16(8'h84, v);
      chk(v, seed[15:0]);
    end
    for (i = 1; i < 8; i = i + 1) begin
      wr16(8'h84, 16'h0000);
      ctrl(4'h0, i[2:0], 2'h0);
      // The start and stop writes add two ticks of their own in the undivided case.
      if (i < 6) repeat ((i == 1) ? 2 : (i < 4) ? (4 << (3 * i - 3)) : (4 << (2 * i))) @(negedge ref_clk);
      else repeat (11) begin
        externalClockPin = !externalClockPin;
        repeat (4) @(negedge ref_clk);
      end
      ctrl(4'h0, 3'h0, 2'h0);
      externalClockPin = 1'b0;
      rd16(8'h84, v);
      if (i < 6) chk({15'h0000, v > 16'h0002 && v < 16'h0006}, 16'h0001);
      else chk(v, (i == 6) ? 16'h0005 : 16'h0006);
    end
    // Modes 0, 5, 6, 7, then the phase correct 1, 2, 3, which also run back down.
    for (i = 0; i < 7; i = i + 1) begin
      m = (i < 4) ? ((i == 0) ? 4'h0 : 4'h4 + i[3:0]) : i[3:0] - 4'h3;
      t = topOf(m);
      seed = xs(seed);
      s = t - {12'h000, seed[3:0]} - 16'h0008;
      e = (i > 3) ? 2 * t - s : t - s;
      ctrl(m, 3'h0, 2'h0);
      wr16(8'h84, s);
      ctrl(m, 3'h1, 2'h0);
      n = 0;
      while (overflowFlagSet !== 1'b1 && n < 1200) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      ctrl(m, 3'h0, 2'h0);
      chk({15'h0000, n > e - 5 && n < e + 5}, 16'h0001);
    end
    ctrl(4'h0, 3'h0, 2'h0);
    for (i = 1; i < 4; i = i + 1) begin
      {compareOutputModeA, compareOutputModeB} = {i[1:0], i[1:0]};
      {pa, pb} = {waveformOutputA, waveformOutputB};
      wr(8'h82, 8'hC0);
      @(negedge ref_clk);
      chk({14'h0000, waveformOutputA, waveformOutputB}, {14'h0000, (i == 1) ? {!pa, !pb} : {i[0], i[0]}});
    end
    ctrl(4'h5, 3'h0, 2'h0);
    pa = waveformOutputA;
    wr(8'h82, 8'h80);
    repeat (2) @(negedge ref_clk);
    chk({15'h0000, waveformOutputA}, {15'h0000, pa});
    wr16(8'h88, 16'h0040);
    wr16(8'h8A, 16'h0042);
    wr16(8'h84, 16'h003C);
    {pa, pb} = 2'h0;
    ctrl(4'h0, 3'h1, 2'h0);
    repeat (12) begin
      @(negedge ref_clk);
      pa = pa | compareMatchASet;
      pb = pb | compareMatchBSet;
    end
    ctrl(4'h0, 3'h0, 2'h0);
    chk({14'h0000, pa, pb}, 16'h0003);
    for (i = 1; i >= 0; i = i - 1) begin
      seed = xs(seed);
      wr16(8'h84, seed[15:0]);
      ctrl(4'h0, 3'h0, {1'b0, i[0]});
      hit = 1'b0;
      pin(i[0], 8);
      rd16(8'h86, v);
      chk({15'h0000, hit}, 16'h0001);
      chk(v, seed[15:0]);
    end
    ctrl(4'h0, 3'h0, 2'h3);
    hit = 1'b0;
    pin(1'b1, 2);
    pin(1'b0, 10);
    chk({15'h0000, hit}, 16'h0000);
    pin(1'b1, 12);
    chk({15'h0000, hit}, 16'h0001);
    ctrl(4'h0, 3'h0, 2'h1);
    hit = 1'b0;
    pin(1'b0, 8);
    chk({15'h0000, hit}, 16'h0000);
    ctrl(4'hC, 3'h0, 2'h1);
    pin(1'b1, 8);
    chk({15'h0000, hit}, 16'h0000);
    end_of_test;
  end
endmodule // tmc_timer16_bench
